//--- design/gpcd_pkg.sv
// constants, types and helpers for the port c/d data register block
package gpcd_pkg;

   // bus geometry
   localparam int unsigned GPCD_ADDR_W   = 8;
   localparam int unsigned GPCD_DATA_W   = 32;
   localparam int unsigned GPCD_PORT_W   = 16;

   // register byte offsets
   localparam logic [7:0]  GPCD_OFF_PORT_C = 8'h00;
   localparam logic [7:0]  GPCD_OFF_PORT_D = 8'h04;
   localparam logic [7:0]  GPCD_OFF_STATUS = 8'h08;

   // reset values
   localparam logic [15:0] GPCD_RST_PIN_DATA = 16'h0000;
   localparam logic [31:0] GPCD_RST_BUS_DATA = 32'h0000_0000;

   // status register fields
   localparam int unsigned GPCD_STS_BOOT_INPUT_BIT = 0;
   localparam int unsigned GPCD_STS_STRAP_DONE_BIT = 1;
   localparam int unsigned GPCD_STS_STRAP_LVL_BIT  = 2;

   // two-bit pin function select encodings
   localparam logic [1:0]  GPCD_FSEL_INPUT    = 2'b00;
   localparam logic [1:0]  GPCD_FSEL_OUTPUT   = 2'b01;
   localparam logic [1:0]  GPCD_FSEL_RESERVED = 2'b10;
   localparam logic [1:0]  GPCD_FSEL_ALT      = 2'b11;

   // last settle count; the strap synchroniser is given four cycles (count 0 to 3) to fill before capture
   localparam logic [1:0]  GPCD_STRAP_SETTLE_CYC = 2'h3;

   // strap capture sequence after power-on reset
   typedef enum logic [1:0]
   {
      GPCD_CAP_SYNC = 2'b00,
      GPCD_CAP_TAKE = 2'b01,
      GPCD_CAP_DONE = 2'b11
   } gpcd_cap_e;

   // true when a read of the bit returns the sampled pin level
   function automatic logic gpcd_reads_pin(input logic [1:0] fsel);
      gpcd_reads_pin = (fsel != GPCD_FSEL_OUTPUT);
   endfunction : gpcd_reads_pin

endpackage : gpcd_pkg

//--- design/gpcd_port_lane.sv
// per-port pin sampling, output enable and read data selection
`timescale 1ns/10ps
module gpcd_port_lane
   import gpcd_pkg::*;
#(
   parameter int unsigned W = GPCD_PORT_W
)
(
   // clock and power-on reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // pins and function select
   input  wire logic [W-1:0] pin_i,
   input  wire logic [W-1:0] fsel_hi_i,
   input  wire logic [W-1:0] fsel_lo_i,
   input  wire logic         force_input_i,
   // stored register value
   input  wire logic [W-1:0] reg_value_i,
   // results
   output logic      [W-1:0] pin_oe_o,
   output logic      [W-1:0] pin_level_o,
   output logic      [W-1:0] read_value_o
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
      logic [W-1:0] oe;
   } gpcd_lane_s;

   gpcd_lane_s        st;
   gpcd_lane_s        next_st;
   logic      [W-1:0] hi_eff;
   logic      [W-1:0] lo_eff;

   // boot default overrides the controller's select with input
   assign hi_eff = force_input_i ? '0 : fsel_hi_i;
   assign lo_eff = force_input_i ? '0 : fsel_lo_i;

   // three-stage sampling, level moves once stages two and three agree
   always_comb
   begin
      next_st       = st;
      next_st.s1    = pin_i;
      next_st.s2    = st.s1;
      next_st.s3    = st.s2;
      next_st.level = (st.s2 & ~(st.s2 ^ st.s3)) | (st.level & (st.s2 ^ st.s3));
      next_st.oe    = ~hi_eff & lo_eff;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st <= '0;
      else
         st <= next_st;
   end

   // per-bit read source: pin level or stored value
   always_comb
   begin
      for (int n = 0; n < W; n++)
      begin
         read_value_o[n] = gpcd_reads_pin({hi_eff[n], lo_eff[n]}) ?
                           st.level[n] : reg_value_i[n];
      end
   end

   assign pin_oe_o    = st.oe;
   assign pin_level_o = st.level;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_oe_follows_sel: assert property (
      !$past(rst_i) |-> pin_oe_o == $past(~hi_eff & lo_eff))
      else $error("output enable does not follow function select");

endmodule : gpcd_port_lane

//--- design/gpcd_top.sv
// port c and port d pin data registers behind a classic wishbone slave
//
// Function
// - each port has one 16-bit read/write data register, one bit per pin.
// - data bit n belongs to pin n of the same port, for n from 15 to 0.
// - power-on reset clears both data registers to zero.
// - manual reset, standby and sleep leave both data registers unchanged.
// - with select 00 or 11 a read of a data bit returns the sampled pin level.
// - with select 01 a read of a data bit returns the stored register value.
// - in output mode a write stores the bit and drives it onto the pin.
// - in input or alternate mode a write stores the bit but does not drive the pin.
// - after power-on with the bus width strap low, port d pins act as inputs; here only from strap capture on, before it port d follows its select.
// - the function controller's selection decides each pin's behaviour.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
module gpcd_top
   import gpcd_pkg::*;
#(
   parameter int unsigned PORT_W = GPCD_PORT_W
)
(
   // clock, power-on reset and manual reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   manual_rst_i,
   // wishbone classic slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [GPCD_ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [GPCD_DATA_W-1:0] wb_dat_i,
   output logic      [GPCD_DATA_W-1:0] wb_dat_o,
   output logic                        wb_ack_o,
   // function selects from the pin function controller
   input  wire logic [PORT_W-1:0]      port_c_func_sel_hi_i,
   input  wire logic [PORT_W-1:0]      port_c_func_sel_lo_i,
   input  wire logic [PORT_W-1:0]      port_d_func_sel_hi_i,
   input  wire logic [PORT_W-1:0]      port_d_func_sel_lo_i,
   input  wire logic                   port_d_function_control_wr_i,
   // boot strap pin
   input  wire logic                   boot_bus_width_strap_i,
   // port c pins
   input  wire logic [PORT_W-1:0]      port_c_pin_i,
   output logic      [PORT_W-1:0]      port_c_pin_o,
   output logic      [PORT_W-1:0]      port_c_pin_oe_o,
   // port d pins
   input  wire logic [PORT_W-1:0]      port_d_pin_i,
   output logic      [PORT_W-1:0]      port_d_pin_o,
   output logic      [PORT_W-1:0]      port_d_pin_oe_o
);

   typedef struct packed
   {
      logic [PORT_W-1:0]      port_c_pin_data;
      logic [PORT_W-1:0]      port_d_pin_data;
      logic                   ack;
      logic [GPCD_DATA_W-1:0] dat;
      gpcd_cap_e              cap;
      logic [1:0]             cap_cnt;
      logic                   strap_s1;
      logic                   strap_s2;
      logic                   strap_s3;
      logic                   strap_low;
      logic                   boot_input;
   } gpcd_top_s;

   gpcd_top_s           st;
   gpcd_top_s           next_st;
   logic                req;
   logic                wr_c;
   logic                wr_d;
   logic [PORT_W-1:0]   read_c;
   logic [PORT_W-1:0]   read_d;
   logic [PORT_W-1:0]   level_c;
   logic [PORT_W-1:0]   level_d;
   logic [GPCD_DATA_W-1:0] status_word;

   // byte-lane merge of a write into a 16-bit data register
   function automatic logic [PORT_W-1:0] gpcd_merge(
      input logic [PORT_W-1:0] old_val,
      input logic [PORT_W-1:0] wr_val,
      input logic [1:0]        sel
   );
      logic [PORT_W-1:0] res;
      res = old_val;
      if (sel[0])
         res[7:0] = wr_val[7:0];
      if (sel[1])
         res[PORT_W-1:8] = wr_val[PORT_W-1:8];
      gpcd_merge = res;
   endfunction : gpcd_merge

   // port c sampling, enables and read selection
   gpcd_port_lane #(
      .W (PORT_W)
   ) u_lane_c (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .pin_i         (port_c_pin_i),
      .fsel_hi_i     (port_c_func_sel_hi_i),
      .fsel_lo_i     (port_c_func_sel_lo_i),
      .force_input_i (1'b0),
      .reg_value_i   (st.port_c_pin_data),
      .pin_oe_o      (port_c_pin_oe_o),
      .pin_level_o   (level_c),
      .read_value_o  (read_c)
   );

   // port d, forced to input while the boot default holds
   gpcd_port_lane #(
      .W (PORT_W)
   ) u_lane_d (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .pin_i         (port_d_pin_i),
      .fsel_hi_i     (port_d_func_sel_hi_i),
      .fsel_lo_i     (port_d_func_sel_lo_i),
      .force_input_i (st.boot_input),
      .reg_value_i   (st.port_d_pin_data),
      .pin_oe_o      (port_d_pin_oe_o),
      .pin_level_o   (level_d),
      .read_value_o  (read_d)
   );

   // request decode; a manual reset holds the bus off
   assign req  = wb_cyc_i & wb_stb_i & ~st.ack & ~manual_rst_i;
   assign wr_c = req & wb_we_i & (wb_adr_i == GPCD_OFF_PORT_C);
   assign wr_d = req & wb_we_i & (wb_adr_i == GPCD_OFF_PORT_D);

   // status word shows the strap capture state
   always_comb
   begin
      status_word                          = '0;
      status_word[GPCD_STS_BOOT_INPUT_BIT] = st.boot_input;
      status_word[GPCD_STS_STRAP_DONE_BIT] = (st.cap == GPCD_CAP_DONE);
      status_word[GPCD_STS_STRAP_LVL_BIT]  = ~st.strap_low;
   end

   // bus slave, data registers and strap capture
   always_comb
   begin
      next_st          = st;
      next_st.ack      = req;
      next_st.strap_s1 = boot_bus_width_strap_i;
      next_st.strap_s2 = st.strap_s1;
      next_st.strap_s3 = st.strap_s2;

      // writes store whatever the pin function is
      if (wr_c)
         next_st.port_c_pin_data = gpcd_merge(st.port_c_pin_data,
                                   wb_dat_i[PORT_W-1:0], wb_sel_i[1:0]);
      if (wr_d)
         next_st.port_d_pin_data = gpcd_merge(st.port_d_pin_data,
                                   wb_dat_i[PORT_W-1:0], wb_sel_i[1:0]);

      // read data, unmapped offsets read zero
      if (req & ~wb_we_i)
      begin
         case (wb_adr_i)
            GPCD_OFF_PORT_C: next_st.dat = {{(GPCD_DATA_W-PORT_W){1'b0}}, read_c};
            GPCD_OFF_PORT_D: next_st.dat = {{(GPCD_DATA_W-PORT_W){1'b0}}, read_d};
            GPCD_OFF_STATUS: next_st.dat = status_word;
            default:         next_st.dat = GPCD_RST_BUS_DATA;
         endcase
      end

      // strap capture once the synchroniser has filled and settled
      case (st.cap)
         GPCD_CAP_SYNC:
         begin
            next_st.cap_cnt = st.cap_cnt + 2'h1;
            if (st.cap_cnt == GPCD_STRAP_SETTLE_CYC)
               next_st.cap = GPCD_CAP_TAKE;
         end
         GPCD_CAP_TAKE:
         begin
            if (st.strap_s2 == st.strap_s3)
            begin
               next_st.strap_low  = ~st.strap_s3;
               next_st.boot_input = ~st.strap_s3;
               next_st.cap        = GPCD_CAP_DONE;
            end
         end
         GPCD_CAP_DONE:
         begin
            // controller programming takes over from the boot default
            if (port_d_function_control_wr_i)
               next_st.boot_input = 1'b0;
         end
         default:
            next_st.cap = GPCD_CAP_SYNC;
      endcase

      // manual reset clears only the bus answer, data is kept
      if (manual_rst_i)
      begin
         next_st.ack = 1'b0;
         next_st.dat = GPCD_RST_BUS_DATA;
      end
   end

   // only power-on reset clears the data registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st                 <= '0;
         st.port_c_pin_data <= GPCD_RST_PIN_DATA;
         st.port_d_pin_data <= GPCD_RST_PIN_DATA;
         st.dat             <= GPCD_RST_BUS_DATA;
         st.cap             <= GPCD_CAP_SYNC;
      end
      else
         st <= next_st;
   end

   // outputs straight from flops
   assign wb_ack_o     = st.ack;
   assign wb_dat_o     = st.dat;
   assign port_c_pin_o = st.port_c_pin_data;
   assign port_d_pin_o = st.port_d_pin_data;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // answer lasts one cycle
   a_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   // data registers read zero right after power-on reset
   a_power_on_clear: assert property (
      $past(rst_i) |-> (port_c_pin_o == 16'h0000) && (port_d_pin_o == 16'h0000))
      else $error("data registers not clear after power-on reset");

   // manual reset keeps data and silences the bus
   a_manual_keeps_data: assert property (
      manual_rst_i |=> $stable(port_c_pin_o) && $stable(port_d_pin_o) && !wb_ack_o)
      else $error("manual reset disturbed data registers");

   // full write to port c lands in one edge
   a_write_stores_c: assert property (
      (wr_c && wb_sel_i[1:0] == 2'b11) |=> port_c_pin_o == $past(wb_dat_i[15:0]))
      else $error("full write to port c not stored");

   // output mode write reaches the pin
   a_write_drives_pin: assert property (
      (wr_d && wb_sel_i[0] && !st.boot_input && port_d_func_sel_hi_i[0] == 1'b0
       && port_d_func_sel_lo_i[0] == 1'b1)
      ##1 ($stable(port_d_func_sel_hi_i[0]) && $stable(port_d_func_sel_lo_i[0]))
      |-> port_d_pin_o[0] == $past(wb_dat_i[0]) && port_d_pin_oe_o[0])
      else $error("output mode write not driven on pin");

   // input select never drives
   a_input_not_driven: assert property (
      (port_c_func_sel_lo_i[3] == 1'b0) [*2] |-> !port_c_pin_oe_o[3])
      else $error("input mode pin is driven");

   // output mode read returns the stored value
   a_read_register: assert property (
      (req && !wb_we_i && wb_adr_i == GPCD_OFF_PORT_C && port_c_func_sel_hi_i == 16'h0000
       && port_c_func_sel_lo_i == 16'hFFFF)
      |=> wb_ack_o && wb_dat_o == {16'h0000, $past(port_c_pin_o)})
      else $error("output mode read did not return stored value");

   // input or alternate read returns the sampled level
   a_read_pin_level: assert property (
      (req && !wb_we_i && wb_adr_i == GPCD_OFF_PORT_C
       && port_c_func_sel_lo_i == port_c_func_sel_hi_i)
      |=> wb_ack_o && wb_dat_o == {16'h0000, $past(level_c)})
      else $error("input or alternate read did not return pin level");

   // boot default reads port d from the pins
   a_boot_input_read: assert property (
      (st.boot_input && req && !wb_we_i && wb_adr_i == GPCD_OFF_PORT_D)
      |=> wb_dat_o == {16'h0000, $past(level_d)})
      else $error("boot default port d read not from pins");

   // strap captured a few cycles after power-on
   a_strap_taken: assert property (
      $past(rst_i) |-> ##[4:12] st.cap == GPCD_CAP_DONE)
      else $error("boot strap not captured in time");

   // full write to port d lands in one edge
   a_write_stores_d: assert property (
      (wr_d && wb_sel_i[1:0] == 2'b11) |=> port_d_pin_o == $past(wb_dat_i[15:0]))
      else $error("full write to port d not stored");

   // low byte write leaves the high byte alone
   a_byte_lane_keep: assert property (
      (wr_c && wb_sel_i[1:0] == 2'b01)
      |=> port_c_pin_o == {$past(port_c_pin_o[15:8]), $past(wb_dat_i[7:0])})
      else $error("byte lane write touched the other byte");

   // every taken request is answered next cycle
   a_ack_follows_req: assert property (
      req |=> wb_ack_o)
      else $error("request not answered");

   // no answer without a request
   a_ack_needs_req: assert property (
      wb_ack_o |-> $past(req))
      else $error("answer without request");

   // boot default keeps port d undriven
   a_boot_no_drive: assert property (
      $past(st.boot_input) |-> port_d_pin_oe_o == 16'h0000)
      else $error("port d driven under boot default");

   // controller programming ends the boot default
   a_boot_flag_clears: assert property (
      (st.cap == GPCD_CAP_DONE && port_d_function_control_wr_i) |=> !st.boot_input)
      else $error("boot default kept after controller write");

   // output select drives the pin one cycle later
   a_output_enables_pin: assert property (
      (!port_c_func_sel_hi_i[0] && port_c_func_sel_lo_i[0]) |=> port_c_pin_oe_o[0])
      else $error("output select did not enable the pin");

   // alternate or reserved select never drives
   a_alt_not_driven: assert property (
      port_c_func_sel_hi_i[0] |=> !port_c_pin_oe_o[0])
      else $error("alternate mode pin is driven");

   // read data holds between read answers
   a_dat_holds: assert property (
      (!$past(rst_i) && !$past(req && !wb_we_i) && !$past(manual_rst_i))
      |-> $stable(wb_dat_o))
      else $error("read data changed without a read");

   // unmapped offsets read zero
   a_unmapped_reads_zero: assert property (
      (req && !wb_we_i && wb_adr_i != GPCD_OFF_PORT_C && wb_adr_i != GPCD_OFF_PORT_D
       && wb_adr_i != GPCD_OFF_STATUS) |=> wb_dat_o == GPCD_RST_BUS_DATA)
      else $error("unmapped read not zero");

   // status word uses only its three low bits
   a_status_upper_zero: assert property (
      (req && !wb_we_i && wb_adr_i == GPCD_OFF_STATUS)
      |=> wb_dat_o[GPCD_DATA_W-1:3] == '0)
      else $error("status upper bits not zero");

   // main scenarios reached
   c_read_port_c: cover property (req && !wb_we_i && wb_adr_i == GPCD_OFF_PORT_C);
   c_write_port_d: cover property (wr_d ##1 port_d_pin_oe_o != 16'h0000);
   c_boot_default: cover property (st.boot_input ##[1:20] !st.boot_input);
   c_manual_reset: cover property (manual_rst_i && port_c_pin_o != 16'h0000);
   c_byte_write: cover property (wr_c && wb_sel_i[1:0] == 2'b01);

endmodule : gpcd_top

//--- testbench/gpcd_board.sv
// board model: pin levels seen by the ports, design drive wins where enabled
`timescale 1ns/10ps
module gpcd_board
#(
   parameter int unsigned W = 16
)
(
   // level the board applies when the pin is not driven
   input  wire logic [W-1:0] drive_level_i,
   // design side of the pins
   input  wire logic [W-1:0] pin_o_i,
   input  wire logic [W-1:0] oe_i,
   // resolved wire level
   output logic      [W-1:0] pin_i_o
);
   // per bit: driven pins show the design value
   assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & drive_level_i);
endmodule : gpcd_board

//--- testbench/tb_gpcd_top.sv
// self-checking bench for the port c/d pin data registers
`timescale 1ns/10ps
module tb_gpcd_top
   import gpcd_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, manual_rst_i = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dwr = 1'b0, strap = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  bsel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [15:0] csh = 16'h0000, csl = 16'h0000, dsh = 16'h0000, dsl = 16'h0000;
   logic [15:0] cbrd = 16'h0000, dbrd = 16'h0000, cpi, cpo, coe, dpi, dpo, doe;
   int          err_total = 0, compares = 0;

   // 125 MHz clock
   always #4 clk_i = ~clk_i;

   gpcd_top i_gpcd_top (.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .port_c_func_sel_hi_i(csh), .port_c_func_sel_lo_i(csl),
      .port_d_func_sel_hi_i(dsh), .port_d_func_sel_lo_i(dsl),
      .port_d_function_control_wr_i(dwr), .boot_bus_width_strap_i(strap),
      .port_c_pin_i(cpi), .port_c_pin_o(cpo), .port_c_pin_oe_o(coe),
      .port_d_pin_i(dpi), .port_d_pin_o(dpo), .port_d_pin_oe_o(doe));
   gpcd_board i_gpcd_board_c (.drive_level_i(cbrd), .pin_o_i(cpo), .oe_i(coe), .pin_i_o(cpi));
   gpcd_board i_gpcd_board_d (.drive_level_i(dbrd), .pin_o_i(dpo), .oe_i(doe), .pin_i_o(dpi));

   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {16'h0000, d};
      bsel <= s;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         chk(32'h0, 32'h1, "no ack");
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      bsel <= 4'h0;
      @(posedge clk_i);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hF, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      wb(1'b0, a, 16'h0000, 4'hF, q);
      chk(q, exp, what);
   endtask : rd

   task automatic por;
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : por

   task automatic t_reset;
      rd(GPCD_OFF_PORT_C, 32'h0, "port c reset");
      rd(GPCD_OFF_PORT_D, 32'h0, "port d reset");
      chk({16'h0, coe}, 32'h0, "c oe reset");
      rd(8'h10, 32'h0, "unmapped read");
      $display("test reset done");
   endtask : t_reset

   task automatic t_output;
      logic [31:0] q;
      csl  <= 16'hFFFF;
      cbrd <= 16'h0F0F;
      repeat (2) @(posedge clk_i);
      wr(GPCD_OFF_PORT_C, 16'hA5C3);
      chk({16'h0, cpo}, 32'hA5C3, "c pin out");
      chk({16'h0, coe}, 32'hFFFF, "c oe output");
      rd(GPCD_OFF_PORT_C, 32'hA5C3, "c stored read");
      wb(1'b1, GPCD_OFF_PORT_C, 16'hFFFF, 4'h1, q);
      chk({16'h0, cpo}, 32'hA5FF, "c low byte write");
      $display("test output done");
   endtask : t_output

   task automatic t_input;
      logic [1:0] m [2];
      m[0] = GPCD_FSEL_INPUT;
      m[1] = GPCD_FSEL_ALT; // reserved 10 never programmed
      foreach (m[i])
      begin
         csh  <= {16{m[i][1]}};
         csl  <= {16{m[i][0]}};
         cbrd <= 16'h1234;
         repeat (6) @(posedge clk_i);
         wr(GPCD_OFF_PORT_C, 16'hFFFF);
         chk({16'h0, coe}, 32'h0, "c oe input");
         rd(GPCD_OFF_PORT_C, 32'h1234, "c pin read");
      end
      csh <= 16'h0000;
      csl <= 16'hFFFF;
      repeat (2) @(posedge clk_i);
      rd(GPCD_OFF_PORT_C, 32'hFFFF, "stored under input");
      $display("test input done");
   endtask : t_input

   task automatic t_mixed;
      csl  <= 16'h00FF;
      cbrd <= 16'hC33C;
      repeat (6) @(posedge clk_i);
      wr(GPCD_OFF_PORT_C, 16'h5A5A);
      chk({16'h0, coe}, 32'h00FF, "c oe mixed");
      rd(GPCD_OFF_PORT_C, 32'hC35A, "c mixed read");
      manual_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      manual_rst_i <= 1'b0;
      @(posedge clk_i);
      chk({16'h0, cpo}, 32'h5A5A, "pin out kept");
      rd(GPCD_OFF_PORT_C, 32'hC35A, "kept after manual");
      $display("test mixed done");
   endtask : t_mixed

   task automatic t_boot;
      dsl  <= 16'hFFFF;
      dbrd <= 16'h6C6C;
      repeat (6) @(posedge clk_i);
      wr(GPCD_OFF_PORT_D, 16'h9393);
      chk({16'h0, doe}, 32'h0, "d oe boot");
      rd(GPCD_OFF_PORT_D, 32'h6C6C, "d boot read");
      rd(GPCD_OFF_STATUS, 32'h3, "status boot");
      dwr <= 1'b1;
      @(posedge clk_i);
      dwr <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({16'h0, doe}, 32'hFFFF, "d oe select");
      rd(GPCD_OFF_PORT_D, 32'h9393, "d stored read");
      wr(GPCD_OFF_PORT_D, 16'h0F0F);
      chk({16'h0, dpo}, 32'h0F0F, "d pin out");
      rd(GPCD_OFF_STATUS, 32'h2, "status after select");
      $display("test boot done");
   endtask : t_boot

   task automatic t_por;
      csl <= 16'hFFFF;
      por();
      chk({16'h0, cpo}, 32'h0, "c pin out por");
      rd(GPCD_OFF_PORT_C, 32'h0, "c por read");
      rd(GPCD_OFF_PORT_D, 32'h6C6C, "d boot again");
      strap <= 1'b1;
      por();
      chk({16'h0, doe}, 32'hFFFF, "d oe strap high");
      rd(GPCD_OFF_STATUS, 32'h6, "status strap high");
      rd(GPCD_OFF_PORT_D, 32'h0, "d follows select");
      $display("test por done");
   endtask : t_por

   // main sequence
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      t_reset();
      t_output();
      t_input();
      t_mixed();
      t_boot();
      t_por();
      final_report();
   end

   // watchdog
   initial
   begin
      #(20000 * 8);
      err_total++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
   end
endmodule : tb_gpcd_top
